// >>> shared/pot_consts.svh
// Shared constants for the serial wiper latch link.
`ifndef POT_CONSTS_SVH
`define POT_CONSTS_SVH
`define POT_CODE_BITS      8
`define POT_TAPS           256
`define POT_MIDSCALE       8'h80
`define POT_CLK_PERIOD_NS  50
`define POT_SCLK_PERIOD_NS 400
`define POT_SCLK_HALF_CYC  (`POT_SCLK_PERIOD_NS / (2 * `POT_CLK_PERIOD_NS))
`define POT_SYNC_RESET     5'h13
`define POT_IN_CS          4
`define POT_IN_SCLK        3
`define POT_IN_SDI         2
`define POT_IN_PRESET      1
`define POT_IN_PDOWN       0
`define POT_FIFO_DEPTH     4
`endif

// >>> shared/pot_pkg.sv
// Types shared by both ends of the serial wiper latch link.
package pot_pkg;
  typedef logic [7:0] code_t;
  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_LOW   = 3'b001,
    H_HIGH  = 3'b010,
    H_TRAIL = 3'b011,
    H_GAP   = 3'b100
  } host_state_t;
endpackage : pot_pkg

// >>> shared/pot_link_if.sv
// Four-wire serial link with preset and shutdown lines between host and device.
`timescale 1ns/1ps
interface pot_link_if;
  logic cs_n;
  logic sclk;
  logic serial_in;
  logic midscale_preset_n;
  logic power_down_n;
  logic sdo_out;
  logic sdo_oe;
  logic serial_out_open_drain;

  // Open drain with pull-up: low only while the device drives.
  assign serial_out_open_drain = sdo_oe ? sdo_out : 1'b1;

  modport device (
    input  cs_n, sclk, serial_in, midscale_preset_n, power_down_n,
    output sdo_out, sdo_oe
  );
  modport host (
    output cs_n, sclk, serial_in, midscale_preset_n, power_down_n,
    input  serial_out_open_drain
  );
endinterface : pot_link_if

// >>> rtl/wiper_device.sv
// Device end: serial shift register, wiper latches, preset, shutdown, tap decode.
`timescale 1ns/1ps
`include "pot_consts.svh"
// Functional notes
// - Single channel host sends 8 bits, MSB first.
// - Dual channel host sends select bit, then eight.
// - Shift serial input on each clock rise, select low.
// - Output bit entered eight shifts earlier.
// - Clock low, select low: hold, output enabled.
// - Select rise loads latch; select high idles.
// - Dual channel uses only last nine bits.
// - Select bit enables one latch, loads eight bits.
// - Select zero first channel, one second.
// - Host updates both channels with two transfers.
// - Preset low forces midscale, clears output latch.
// - Preset release with select high holds 80h.
// - Shutdown opens A, wiper to B, output off.
// - Shutdown keeps latch contents.
// - Power-on sets every wiper latch to midscale.
// - Chain of two: host shifts sixteen bits, eighteen when dual channel.
// - Host holds select low until chain loaded.
// - Host slows clock for daisy chaining; here SCLK_HALF is fixed and does not change with CHAIN_DEVICES.
// - Decode code to one of 256 taps.
module wiper_device #(
  parameter int CHANNELS = 2
) (
  input  wire logic                                    clk,
  input  wire logic                                    rst,
  pot_link_if.device                                   link,
  output logic       [CHANNELS-1:0][`POT_CODE_BITS-1:0] wiper_code,
  output logic       [CHANNELS-1:0][`POT_TAPS-1:0]      tap_on,
  output logic                                         terminal_a_open,
  output logic                                         wiper_to_b
);

  ////////////////////////////////////////////////////////////////////////////
  // One-hot tap decode of a latch code.
  function automatic logic [`POT_TAPS-1:0] decode_tap(input pot_pkg::code_t code);
    logic [`POT_TAPS-1:0] onehot;
    onehot = '0;
    onehot[code] = 1'b1;
    return onehot;
  endfunction : decode_tap

  // Channel match of the select bit; a single channel takes every word.
  function automatic logic chan_hit(input logic sel_bit, input int chan);
    return (CHANNELS == 2) ? (int'(sel_bit) == chan) : (chan == 0);
  endfunction : chan_hit

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers with agreement filter.
  logic [4:0] pins;
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [4:0] sync3_q;
  logic [4:0] filt_q;
  logic [4:0] filt_d;
  logic [4:0] prev_q;

  assign pins = {link.cs_n, link.sclk, link.serial_in, link.midscale_preset_n,
                 link.power_down_n};

  always_comb begin
    filt_d = (sync2_q & ~(sync2_q ^ sync3_q)) | (filt_q & (sync2_q ^ sync3_q));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= `POT_SYNC_RESET;
      sync2_q <= `POT_SYNC_RESET;
      sync3_q <= `POT_SYNC_RESET;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // The filtered levels start at the idle levels so no false edge follows reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      filt_q <= `POT_SYNC_RESET;
      prev_q <= `POT_SYNC_RESET;
    end else begin
      filt_q <= filt_d;
      prev_q <= filt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift register, output latch and wiper latches.
  logic                                    cs_n;
  logic                                    sclk_rise;
  logic                                    cs_rise;
  logic                                    preset_n;
  logic                                    pdown_n;
  logic [8:0]                              sr_q;
  logic [8:0]                              sr_d;
  logic                                    sout_q;
  logic                                    sout_d;
  logic                                    oe_q;
  logic                                    oe_d;
  logic [CHANNELS-1:0][`POT_CODE_BITS-1:0] wiper_q;
  logic [CHANNELS-1:0][`POT_TAPS-1:0]      tap_q;
  logic                                    aopen_q;
  logic                                    aopen_d;

  ////////////////////////////////////////////////////////////////////////////
  // Filtered pin levels and edges.
  assign cs_n      = filt_q[`POT_IN_CS];
  assign preset_n  = filt_q[`POT_IN_PRESET];
  assign pdown_n   = filt_q[`POT_IN_PDOWN];
  assign sclk_rise = filt_q[`POT_IN_SCLK] & ~prev_q[`POT_IN_SCLK];
  assign cs_rise   = filt_q[`POT_IN_CS] & ~prev_q[`POT_IN_CS];

  ////////////////////////////////////////////////////////////////////////////
  // Shift register and serial output latch.
  always_comb begin
    sr_d   = sr_q;
    sout_d = sout_q;
    // Outside a clock rise the register holds.
    if (!cs_n && sclk_rise) begin
      sout_d = sr_q[7];
      sr_d   = {sr_q[7:0], filt_q[`POT_IN_SDI]};
    end
    if (!preset_n) begin
      sout_d = 1'b0;
    end
    oe_d = pdown_n & ~cs_n & ~sout_d;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sr_q   <= '0;
      sout_q <= 1'b0;
      oe_q   <= 1'b0;
    end else begin
      sr_q   <= sr_d;
      sout_q <= sout_d;
      oe_q   <= oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wiper latch and tap decode of each channel.
  generate
    for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
      logic [`POT_CODE_BITS-1:0] code_q;
      logic [`POT_CODE_BITS-1:0] code_d;
      logic [`POT_TAPS-1:0]      taps_q;
      logic [`POT_TAPS-1:0]      taps_d;

      always_comb begin
        code_d = code_q;
        if (cs_rise && chan_hit(sr_q[8], c)) begin
          code_d = sr_q[7:0];
        end
        if (!preset_n) begin
          code_d = `POT_MIDSCALE;
        end
        taps_d = decode_tap(code_d);
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          code_q <= `POT_MIDSCALE;
          taps_q <= decode_tap(`POT_MIDSCALE);
        end else begin
          code_q <= code_d;
          taps_q <= taps_d;
        end
      end

      assign wiper_q[c] = code_q;
      assign tap_q[c]   = taps_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Shutdown control of the resistor terminals.
  always_comb begin
    aopen_d = ~pdown_n;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      aopen_q <= 1'b0;
    end else begin
      aopen_q <= aopen_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link and block outputs.
  assign link.sdo_out    = 1'b0;
  assign link.sdo_oe     = oe_q;
  assign wiper_code      = wiper_q;
  assign tap_on          = tap_q;
  assign terminal_a_open = aopen_q;
  assign wiper_to_b      = aopen_q;

endmodule : wiper_device

// >>> rtl/wiper_host.sv
// Host end: frame FIFO and serial link master with clock divider.
`timescale 1ns/1ps
`include "pot_consts.svh"
module frame_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = `POT_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        mem[wr_q] <= in_data;
        wr_q      <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : frame_fifo

////////////////////////////////////////////////////////////////////////////////
// Serial master: one frame per FIFO word, far device bits first.
module wiper_host #(
  parameter int CHANNELS      = 2,
  parameter int CHAIN_DEVICES = 1,
  parameter int SCLK_HALF     = `POT_SCLK_HALF_CYC
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  pot_link_if.host                     link,
  input  wire logic                    frame_valid,
  output logic                         frame_ready,
  input  wire logic [CHAIN_DEVICES*((CHANNELS == 2) ? 9 : 8)-1:0] frame_data,
  input  wire logic                    preset_req_n,
  input  wire logic                    power_down_req_n,
  output logic                         busy,
  output logic [CHAIN_DEVICES*((CHANNELS == 2) ? 9 : 8)-1:0] readback
);
  localparam int WORD_BITS = (CHANNELS == 2) ? 9 : 8;
  localparam int FRAME     = CHAIN_DEVICES * WORD_BITS;

  logic                     f_valid;
  logic                     f_pop;
  logic [FRAME-1:0]         f_data;
  pot_pkg::host_state_t     state_q;
  pot_pkg::host_state_t     state_d;
  logic [7:0]               div_q;
  logic [7:0]               div_d;
  logic [7:0]               bits_q;
  logic [7:0]               bits_d;
  logic [FRAME-1:0]         frame_q;
  logic [FRAME-1:0]         frame_d;
  logic [FRAME-1:0]         rx_q;
  logic [FRAME-1:0]         rx_d;
  logic [FRAME-1:0]         rb_q;
  logic [FRAME-1:0]         rb_d;
  logic                     cs_n_q;
  logic                     cs_n_d;
  logic                     sclk_q;
  logic                     sclk_d;
  logic                     sdi_q;
  logic                     sdi_d;
  logic                     pr_q;
  logic                     pd_q;
  logic [2:0]               sdo_sync_q;
  logic                     sdo_f_q;
  logic                     tick;

  frame_fifo #(.WIDTH(FRAME), .DEPTH(`POT_FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (frame_valid),
    .in_ready  (frame_ready),
    .in_data   (frame_data),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  assign tick  = (div_q == '0);
  assign f_pop = (state_q == pot_pkg::H_IDLE) & f_valid;

  always_comb begin
    state_d = state_q;
    div_d   = tick ? 8'(SCLK_HALF - 1) : div_q - 8'h01;
    bits_d  = bits_q;
    frame_d = frame_q;
    rx_d    = rx_q;
    rb_d    = rb_q;
    cs_n_d  = cs_n_q;
    sclk_d  = sclk_q;
    sdi_d   = sdi_q;
    case (state_q)
      pot_pkg::H_IDLE: begin
        div_d = 8'(SCLK_HALF - 1);
        if (f_valid) begin
          frame_d = f_data;
          sdi_d   = f_data[FRAME-1];
          bits_d  = 8'(FRAME);
          cs_n_d  = 1'b0;
          state_d = pot_pkg::H_LOW;
        end
      end
      pot_pkg::H_LOW: begin
        if (tick) begin
          rx_d    = {rx_q[FRAME-2:0], sdo_f_q};
          sclk_d  = 1'b1;
          state_d = pot_pkg::H_HIGH;
        end
      end
      pot_pkg::H_HIGH: begin
        if (tick) begin
          sclk_d  = 1'b0;
          bits_d  = bits_q - 8'h01;
          frame_d = frame_q << 1;
          sdi_d   = frame_d[FRAME-1];
          // Select stays low until every chained word is in.
          state_d = (bits_q == 8'h01) ? pot_pkg::H_TRAIL : pot_pkg::H_LOW;
        end
      end
      pot_pkg::H_TRAIL: begin
        if (tick) begin
          cs_n_d  = 1'b1;
          state_d = pot_pkg::H_GAP;
        end
      end
      pot_pkg::H_GAP: begin
        if (tick) begin
          rb_d    = rx_q;
          state_d = pot_pkg::H_IDLE;
        end
      end
      default: begin
        state_d = pot_pkg::H_IDLE;
        cs_n_d  = 1'b1;
        sclk_d  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q    <= pot_pkg::H_IDLE;
      div_q      <= '0;
      bits_q     <= '0;
      frame_q    <= '0;
      rx_q       <= '0;
      rb_q       <= '0;
      cs_n_q     <= 1'b1;
      sclk_q     <= 1'b0;
      sdi_q      <= 1'b0;
      pr_q       <= 1'b1;
      pd_q       <= 1'b1;
      sdo_sync_q <= 3'h7;
      sdo_f_q    <= 1'b1;
    end else begin
      state_q    <= state_d;
      div_q      <= div_d;
      bits_q     <= bits_d;
      frame_q    <= frame_d;
      rx_q       <= rx_d;
      rb_q       <= rb_d;
      cs_n_q     <= cs_n_d;
      sclk_q     <= sclk_d;
      sdi_q      <= sdi_d;
      pr_q       <= preset_req_n;
      pd_q       <= power_down_req_n;
      sdo_sync_q <= {sdo_sync_q[1:0], link.serial_out_open_drain};
      if (sdo_sync_q[1] == sdo_sync_q[2]) begin
        sdo_f_q <= sdo_sync_q[1];
      end
    end
  end

  assign link.cs_n              = cs_n_q;
  assign link.sclk              = sclk_q;
  assign link.serial_in         = sdi_q;
  assign link.midscale_preset_n = pr_q;
  assign link.power_down_n      = pd_q;
  assign busy                   = (state_q != pot_pkg::H_IDLE);
  assign readback               = rb_q;

endmodule : wiper_host

// >>> verification/link_sva.sv
// Concurrent checks on the serial link between the host and device ends.
`timescale 1ns/1ps
module link_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic midscale_preset_n,
  input wire logic power_down_n,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire logic serial_out_open_drain
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Counts serial clock rises inside one frame.
  logic       sclk_q;
  logic [3:0] rise_q;
  logic [3:0] rise_d;
  always_comb begin
    rise_d = rise_q;
    if (cs_n) begin
      rise_d = 4'h0;
    end else if (sclk && !sclk_q) begin
      rise_d = rise_q + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    sclk_q <= rst ? 1'b0 : sclk;
    rise_q <= rst ? 4'h0 : rise_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  frame_len_a: assert property ($rose(cs_n) |-> rise_q == 4'h9)
    else $error("frame did not carry nine clock rises");
  sclk_frame_a: assert property ($rose(sclk) |-> !cs_n)
    else $error("serial clock rose outside a frame");
  data_stable_a: assert property ($rose(sclk) |-> $stable(serial_in))
    else $error("serial data moved at the clock rise");
  cs_rise_a: assert property ($rose(cs_n) |-> !sclk)
    else $error("select rose with serial clock high");
  sclk_high_a: assert property ($rose(sclk) |=> sclk [*3] ##1 !sclk)
    else $error("serial clock high phase not four cycles");
  shutdown_off_a: assert property (!power_down_n [*8] |-> !sdo_oe)
    else $error("output driven during shutdown");
  idle_off_a: assert property (cs_n [*8] |-> !sdo_oe)
    else $error("output driven with select high");
  drive_low_a: assert property (sdo_oe |-> !sdo_out && !serial_out_open_drain)
    else $error("open drain output drove high");
  preset_clear_a: assert property
    ((!midscale_preset_n && !cs_n && power_down_n) [*8] |-> sdo_oe)
    else $error("output latch not cleared by preset");

  frame_c: cover property ($rose(cs_n));
  shutdown_c: cover property (!power_down_n [*8]);
  preset_c: cover property (!midscale_preset_n && !cs_n);
endmodule : link_sva

// >>> verification/tb_top.sv
// Self-checking bench for the host and device ends joined by one link.
`timescale 1ns/1ps
module tb_top;
  logic              clk;
  logic              rst;
  logic              frame_valid;
  logic              frame_ready;
  logic [8:0]        frame_data;
  logic              preset_req_n;
  logic              power_down_req_n;
  logic              busy;
  logic [1:0][7:0]   wiper_code;
  logic [1:0][255:0] tap_on;
  logic              terminal_a_open;
  logic              wiper_to_b;
  logic              refused;
  logic [8:0]        d;
  int                fail_count;
  int                check_count;
  int                seed;
  int                exp_code [2];

  pot_link_if link ();

  wiper_host #(.CHANNELS(2)) i_wiper_host (
    .clk(clk), .rst(rst), .link(link), .frame_valid(frame_valid),
    .frame_ready(frame_ready), .frame_data(frame_data), .preset_req_n(preset_req_n),
    .power_down_req_n(power_down_req_n), .busy(busy), .readback()
  );
  wiper_device #(.CHANNELS(2)) i_wiper_device (
    .clk(clk), .rst(rst), .link(link), .wiper_code(wiper_code), .tap_on(tap_on),
    .terminal_a_open(terminal_a_open), .wiper_to_b(wiper_to_b)
  );
  link_sva i_link_sva (
    .clk(clk), .rst(rst), .cs_n(link.cs_n), .sclk(link.sclk), .serial_in(link.serial_in),
    .midscale_preset_n(link.midscale_preset_n), .power_down_n(link.power_down_n),
    .sdo_out(link.sdo_out), .sdo_oe(link.sdo_oe),
    .serial_out_open_drain(link.serial_out_open_drain)
  );

  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks.
  task automatic stop_test;
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic send(input logic [8:0] w);
    logic r;
    r = 1'b0;
    frame_valid <= 1'b1;
    frame_data  <= w;
    for (int n = 0; n < 2000 && !r; n++) begin
      @(negedge clk);
      r = (frame_ready === 1'b1);
      if (!r) refused = 1'b1;
      @(posedge clk);
    end
    if (!r) begin
      fail_count++;
      stop_test();
    end
    exp_code[w[8]] = w[7:0];
  endtask : send

  task automatic wait_idle;
    int q;
    q = 0;
    frame_valid <= 1'b0;
    for (int n = 0; n < 4000 && q < 30; n++) begin
      @(negedge clk);
      q = (busy === 1'b0) ? q + 1 : 0;
    end
    if (q < 30) begin
      fail_count++;
      stop_test();
    end
    @(posedge clk);
  endtask : wait_idle

  task automatic check_all;
    for (int c = 0; c < 2; c++) begin
      chk(wiper_code[c], exp_code[c]);
      chk(tap_on[c], 256'h1 << exp_code[c]);
    end
  endtask : check_all

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    frame_valid = 1'b0;
    frame_data = 9'h000;
    preset_req_n = 1'b1;
    power_down_req_n = 1'b1;
    refused = 1'b0;
    fail_count = 0;
    check_count = 0;
    seed = 32'h8C21;
    exp_code[0] = 32'h80;
    exp_code[1] = 32'h80;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wait_idle();
    check_all();
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : {i[0], 8'($random(seed))};
      send(d);
      wait_idle();
      check_all();
    end
    for (int i = 0; i < 6; i++) begin
      send({i[1], 8'($random(seed))});
    end
    wait_idle();
    chk(refused, 1'b1);
    check_all();
    power_down_req_n <= 1'b0;
    repeat (12) @(posedge clk);
    chk(terminal_a_open, 1'b1);
    chk(wiper_to_b, 1'b1);
    chk(link.serial_out_open_drain, 1'b1);
    check_all();
    power_down_req_n <= 1'b1;
    repeat (12) @(posedge clk);
    chk(terminal_a_open, 1'b0);
    check_all();
    send(9'h1A5);
    frame_valid <= 1'b0;
    repeat (20) @(posedge clk);
    preset_req_n <= 1'b0;
    wait_idle();
    exp_code[0] = 32'h80;
    exp_code[1] = 32'h80;
    check_all();
    preset_req_n <= 1'b1;
    repeat (12) @(posedge clk);
    check_all();
    send(9'h03C);
    wait_idle();
    check_all();
    stop_test();
  end
endmodule : tb_top
